// ===== design/cmm_pkg.sv
package cmm_pkg;

  // ----------------------------------------------------------------------------
  // Program space
  // ----------------------------------------------------------------------------
  localparam int PC_W = 13;
  localparam int FETCH_W = 9;
  localparam int WORD_W = 14;
  localparam logic [12:0] PC_RESET_VEC = 13'h0000;
  localparam logic [12:0] PC_INT_VEC = 13'h0004;
  localparam logic [8:0] HEF_LO = 9'h180;
  localparam logic [8:0] HEF_HI = 9'h1ff;

  // ----------------------------------------------------------------------------
  // Data memory map, single bank
  // ----------------------------------------------------------------------------
  localparam int DM_AW = 7;
  localparam int RAM_DEPTH = 64;
  localparam logic [6:0] DM_INDIRECT = 7'h00;
  localparam logic [6:0] DM_PC_LOW = 7'h02;
  localparam logic [6:0] DM_STATUS = 7'h03;
  localparam logic [6:0] DM_POINTER = 7'h04;
  localparam logic [6:0] DM_PC_LATCH_HIGH = 7'h0a;
  localparam logic [6:0] DM_RAM_BASE = 7'h40;
  localparam int LATCH_W = 5;

  // ----------------------------------------------------------------------------
  // Status word layout and value after reset
  // ----------------------------------------------------------------------------
  localparam int ST_CARRY = 0;
  localparam int ST_NIBBLE = 1;
  localparam int ST_ZERO = 2;
  localparam int ST_SLEEP = 3;
  localparam int ST_WDT = 4;
  localparam int ST_BANK_LO = 5;
  localparam int ST_BANK_HI = 6;
  localparam int ST_IND_HIGH = 7;
  localparam logic [7:0] STATUS_RESET = 8'h18;

  // ----------------------------------------------------------------------------
  // Software registers on the AXI4-Lite slave
  // ----------------------------------------------------------------------------
  localparam int AXI_AW = 8;
  localparam logic [7:0] AXI_CTRL = 8'h00;
  localparam logic [7:0] AXI_STATUS = 8'h04;
  localparam logic [7:0] AXI_PC = 8'h08;
  localparam logic [7:0] AXI_POINTER = 8'h0c;
  localparam logic [7:0] AXI_PEEK_ADDR = 8'h10;
  localparam logic [7:0] AXI_PEEK_DATA = 8'h14;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ----------------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NONE, OP_READ, OP_MOVE_W, OP_CLEAR, OP_ADD, OP_SUB, OP_AND,
    OP_BIT_CLEAR, OP_BIT_SET, OP_NIBBLE_SWAP
  } cmm_op_t;

  typedef enum logic [2:0] {
    RG_INDIRECT, RG_PC_LOW, RG_STATUS, RG_POINTER, RG_LATCH, RG_RAM, RG_UNIMPL
  } cmm_region_t;

  typedef struct packed {
    logic z;
    logic dc;
    logic c;
  } cmm_flags_t;

  typedef struct packed {
    logic valid;
    cmm_op_t op;
    logic [6:0] addr;
    logic [7:0] w;
    logic [2:0] bit_sel;
  } cmm_core_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] old_data;
    logic [7:0] result;
  } cmm_core_rsp_t;

  typedef struct packed {
    logic inc;
    logic load;
    logic [12:0] target;
    logic int_accept;
  } cmm_pc_ctl_t;

  typedef struct packed {
    logic wdt_timeout;
    logic wdt_clear;
    logic sleep_exec;
  } cmm_hw_evt_t;

  // Sorts a bank address into the kind of storage behind it.
  function automatic cmm_region_t dm_region(input logic [6:0] a);
    if (a >= DM_RAM_BASE) begin
      return RG_RAM;
    end
    case (a)
      DM_INDIRECT: return RG_INDIRECT;
      DM_PC_LOW: return RG_PC_LOW;
      DM_STATUS: return RG_STATUS;
      DM_POINTER: return RG_POINTER;
      DM_PC_LATCH_HIGH: return RG_LATCH;
      default: return RG_UNIMPL;
    endcase
  endfunction : dm_region

endpackage : cmm_pkg

// ===== design/cmm_alu.sv
`timescale 1ns/1ps
`default_nettype none

module cmm_alu import cmm_pkg::*; (
  input wire cmm_op_t op,
  input wire logic [7:0] f,
  input wire logic [7:0] w,
  input wire logic [2:0] bit_sel,
  output var logic [7:0] result,
  output var logic writes,
  output var cmm_flags_t flags,
  output var cmm_flags_t touch
);

  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] bit_mask;

  // ----------------------------------------------------------------------------
  // Result and flag computation
  // ----------------------------------------------------------------------------
  // Subtraction adds the two's complement, so both carries come out as inverted borrows.
  always_comb begin
    bit_mask = 8'h01 << bit_sel;
    sum = 9'h000;
    nib = 5'h00;
    result = f;
    writes = 1'b1;
    touch = '0;
    case (op)
      OP_MOVE_W: result = w;
      OP_CLEAR: begin
        result = 8'h00;
        touch.z = 1'b1;
      end
      OP_ADD: begin
        sum = {1'b0, f} + {1'b0, w};
        nib = {1'b0, f[3:0]} + {1'b0, w[3:0]};
        result = sum[7:0];
        touch = '1;
      end
      OP_SUB: begin
        sum = {1'b0, f} + {1'b0, ~w} + 9'h001;
        nib = {1'b0, f[3:0]} + {1'b0, ~w[3:0]} + 5'h01;
        result = sum[7:0];
        touch = '1;
      end
      OP_AND: begin
        result = f & w;
        touch.z = 1'b1;
      end
      OP_BIT_CLEAR: result = f & ~bit_mask;
      OP_BIT_SET: result = f | bit_mask;
      OP_NIBBLE_SWAP: result = {f[3:0], f[7:4]};
      default: writes = 1'b0;
    endcase
    flags.z = (result == 8'h00);
    flags.dc = nib[4];
    flags.c = sum[8];
  end

endmodule : cmm_alu

`default_nettype wire

// ===== design/cmm_core_map.sv
// What this block does
// - Program counter is 13 bits, addressing 8K words of 14 bits.
// - Only 512 words exist; higher fetch addresses wrap into them.
// - Reset starts at address zero; an accepted interrupt jumps to four.
// - High-endurance range 180h-1FFh covers only each word's low byte.
// - Data memory is one bank, bank bits zero, 128 bytes up to 7Fh.
// - Special registers sit at the bottom, general RAM above them.
// - General RAM is 64 bytes, reached directly or via the pointer.
// - The status word may be the destination of any instruction.
// - Flag-updating instructions discard written zero and carry bits, keep computed ones.
// - Watchdog and sleep flags ignore software writes; hardware alone changes them.
// - Clearing status zeroes top three bits, sets zero, keeps the rest.
// - In subtraction both carry flags act as inverted borrows.
// - Zero flag is set when a result is zero, else cleared.
// - Nibble flag is carry out of bit 3, carry flag out of bit 7.
// - Watchdog flag reads 1 after power-up, clear or sleep; 0 after timeout.
`timescale 1ns/1ps
`default_nettype none

module cmm_core_map import cmm_pkg::*; (
  input wire logic clk,
  input wire logic srst,
  input wire cmm_core_req_t core_req,
  input wire cmm_pc_ctl_t pc_ctl,
  input wire cmm_hw_evt_t hw_evt,
  output var cmm_core_rsp_t core_rsp,
  output var logic [8:0] fetch_addr,
  output var logic hef_low_byte,
  output var logic [7:0] status_word,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output var logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output var logic s_axi_wready,
  output var logic [1:0] s_axi_bresp,
  output var logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output var logic s_axi_arready,
  output var logic [31:0] s_axi_rdata,
  output var logic [1:0] s_axi_rresp,
  output var logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic [12:0] pc;
    logic hef;
    logic [7:0] status;
    logic [7:0] pointer;
    logic [4:0] latch_high;
    // General RAM, 64 bytes.
    logic [63:0][7:0] ram;
    cmm_core_rsp_t rsp;
    logic hold;
    logic [6:0] peek_addr;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } cmm_state_t;

  cmm_state_t s;
  cmm_state_t next_s;

  logic [6:0] eff_addr;
  logic eff_ok;
  logic [7:0] rd_byte;
  logic [7:0] alu_result;
  logic alu_writes;
  cmm_flags_t alu_flags;
  cmm_flags_t alu_touch;
  logic pcl_write;
  logic [7:0] wr_off;
  logic [7:0] rd_off;

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  // Reads one bank location; the indirect slot itself holds nothing and reads zero.
  function automatic logic [7:0] dm_read(
    input cmm_state_t st,
    input logic [6:0] a
  );
    logic [5:0] idx;
    idx = a[5:0];
    case (dm_region(a))
      RG_PC_LOW: return st.pc[7:0];
      RG_STATUS: return st.status;
      RG_POINTER: return st.pointer;
      RG_LATCH: return {3'b000, st.latch_high};
      RG_RAM: return st.ram[idx];
      default: return 8'h00;
    endcase
  endfunction : dm_read

  // Word offset of an AXI byte address, low two bits ignored.
  function automatic logic [7:0] word_off(input logic [7:0] a);
    return {a[7:2], 2'b00};
  endfunction : word_off

  // ----------------------------------------------------------------------------
  // Flag and result arithmetic
  // ----------------------------------------------------------------------------
  cmm_alu u_alu (
    .op(core_req.valid ? core_req.op : OP_NONE),
    .f(rd_byte),
    .w(core_req.w),
    .bit_sel(core_req.bit_sel),
    .result(alu_result),
    .writes(alu_writes),
    .flags(alu_flags),
    .touch(alu_touch)
  );

  // ----------------------------------------------------------------------------
  // Operand fetch through the direct or indirect path
  // ----------------------------------------------------------------------------
  // The pointer's top bit would leave the single bank, so such accesses act as unimplemented.
  always_comb begin
    eff_addr = core_req.addr;
    eff_ok = 1'b1;
    if (dm_region(core_req.addr) == RG_INDIRECT) begin
      eff_addr = s.pointer[6:0];
      eff_ok = ~s.pointer[7] &&
               (dm_region(s.pointer[6:0]) != RG_INDIRECT);
    end
    rd_byte = eff_ok ? dm_read(s, eff_addr) : 8'h00;
  end

  // ----------------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.rsp.valid = 1'b0;
    pcl_write = 1'b0;
    wr_off = word_off(s.aw_addr);
    rd_off = word_off(s_axi_araddr);

    // Core access: read the operand, answer the core, write the result back.
    if (core_req.valid && (core_req.op != OP_NONE)) begin
      next_s.rsp.valid = 1'b1;
      next_s.rsp.old_data = rd_byte;
      next_s.rsp.result = alu_result;
    end
    if (alu_writes && eff_ok) begin
      case (dm_region(eff_addr))
        RG_PC_LOW: pcl_write = 1'b1;
        RG_STATUS: begin
          // Only the bank and indirect-high bits, and the flag bits when no flag is computed, take the written value.
          next_s.status[ST_IND_HIGH:ST_BANK_LO] =
            alu_result[ST_IND_HIGH:ST_BANK_LO];
          if (alu_touch == 3'b000) begin
            next_s.status[ST_ZERO:ST_CARRY] =
              alu_result[ST_ZERO:ST_CARRY];
          end
          // Watchdog and sleep bits are never taken from the written value.
        end
        RG_POINTER: next_s.pointer = alu_result;
        RG_LATCH: next_s.latch_high = alu_result[LATCH_W-1:0];
        RG_RAM: next_s.ram[eff_addr[5:0]] = alu_result;
        default: next_s.pointer = next_s.pointer;
      endcase
    end

    // Computed flags override anything the instruction wrote to the status word.
    if (core_req.valid) begin
      if (alu_touch.z) begin
        next_s.status[ST_ZERO] = alu_flags.z;
      end
      if (alu_touch.dc) begin
        next_s.status[ST_NIBBLE] = alu_flags.dc;
      end
      if (alu_touch.c) begin
        next_s.status[ST_CARRY] = alu_flags.c;
      end
    end

    // Hardware events own the watchdog and sleep flags; a timeout beats a clear.
    if (hw_evt.wdt_clear) begin
      next_s.status[ST_WDT] = 1'b1;
      next_s.status[ST_SLEEP] = 1'b1;
    end
    if (hw_evt.sleep_exec) begin
      next_s.status[ST_WDT] = 1'b1;
      next_s.status[ST_SLEEP] = 1'b0;
    end
    if (hw_evt.wdt_timeout) begin
      next_s.status[ST_WDT] = 1'b0;
    end

    // Program counter: interrupt vector first, then a low-byte write, jump, step.
    // Hold stops only the step; jumps still land.
    if (pc_ctl.int_accept) begin
      next_s.pc = PC_INT_VEC;
    end else if (pcl_write) begin
      next_s.pc = {s.latch_high, alu_result};
    end else if (pc_ctl.load) begin
      next_s.pc = pc_ctl.target;
    end else if (pc_ctl.inc && !s.hold) begin
      next_s.pc = s.pc + 13'h0001;
    end
    // Only the low byte of each word in the top range is high-endurance storage.
    next_s.hef = (next_s.pc[FETCH_W-1:0] >= HEF_LO) &&
                 (next_s.pc[FETCH_W-1:0] <= HEF_HI);

    // AXI write: address and data are taken in either order, then answered together.
    if (s.awready && s_axi_awvalid) begin
      next_s.aw_got = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s.wready && s_axi_wvalid) begin
      next_s.w_got = 1'b1;
      next_s.wdata = s_axi_wdata;
      next_s.wstrb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.aw_got && s.w_got && !s.bvalid) begin
      wr_off = word_off(s.aw_addr);
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      case (wr_off)
        AXI_CTRL: begin
          if (s.wstrb[0]) begin
            next_s.hold = s.wdata[0];
          end
        end
        AXI_PEEK_ADDR: begin
          if (s.wstrb[0]) begin
            next_s.peek_addr = s.wdata[DM_AW-1:0];
          end
        end
        // Read-only words drop the write, answering OKAY.
        AXI_STATUS, AXI_PC, AXI_POINTER, AXI_PEEK_DATA: next_s.bresp = RESP_OKAY;
        default: next_s.bresp = RESP_SLVERR;
      endcase
    end
    // Readies stay low until the answer is taken.
    next_s.awready = !next_s.aw_got && !next_s.bvalid;
    next_s.wready = !next_s.w_got && !next_s.bvalid;

    // AXI read: one outstanding read, answered on the cycle after it is taken.
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
      next_s.arready = 1'b1;
    end
    if (s.arready && s_axi_arvalid) begin
      next_s.arready = 1'b0;
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OKAY;
      case (rd_off)
        AXI_CTRL: next_s.rdata = {31'h00000000, s.hold};
        AXI_STATUS: next_s.rdata = {24'h000000, s.status};
        AXI_PC: next_s.rdata = {19'h00000, s.pc};
        AXI_POINTER: next_s.rdata = {24'h000000, s.pointer};
        AXI_PEEK_ADDR: next_s.rdata = {25'h0000000, s.peek_addr};
        AXI_PEEK_DATA: next_s.rdata = {24'h000000, dm_read(s, s.peek_addr)};
        default: begin
          next_s.rdata = 32'h00000000;
          next_s.rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------------
  // General RAM keeps its contents over reset; only control state is cleared.
  always_ff @(posedge clk) begin
    if (srst) begin
      // Copying next_s first keeps the RAM over reset.
      s <= next_s;
      s.pc <= PC_RESET_VEC;
      s.hef <= 1'b0;
      s.status <= STATUS_RESET;
      s.pointer <= 8'h00;
      s.latch_high <= 5'h00;
      s.rsp <= '0;
      s.hold <= 1'b0;
      s.peek_addr <= 7'h00;
      s.aw_got <= 1'b0;
      s.aw_addr <= 8'h00;
      s.w_got <= 1'b0;
      s.wdata <= 32'h00000000;
      s.wstrb <= 4'h0;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.bvalid <= 1'b0;
      s.bresp <= RESP_OKAY;
      s.arready <= 1'b1;
      s.rvalid <= 1'b0;
      s.rresp <= RESP_OKAY;
      s.rdata <= 32'h00000000;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------------------
  assign core_rsp = s.rsp;
  assign fetch_addr = s.pc[FETCH_W-1:0];
  assign hef_low_byte = s.hef;
  assign status_word = s.status;
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rdata = s.rdata;

endmodule : cmm_core_map

`default_nettype wire

// ===== bench/cmm_core_map_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module cmm_core_map_checker import cmm_pkg::*; (
  input wire logic clk,
  input wire logic srst,
  input wire cmm_core_req_t core_req,
  input wire cmm_pc_ctl_t pc_ctl,
  input wire cmm_hw_evt_t hw_evt,
  input wire cmm_core_rsp_t core_rsp,
  input wire logic [8:0] fetch_addr,
  input wire logic hef_low_byte,
  input wire logic [7:0] status_word,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  // -------------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------------
  // One clock domain, so clock and reset are given once for every assertion.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  logic st_wr;
  logic [8:0] st_sum;
  // A software write to the status word with no hardware event racing it, since events win.
  assign st_wr = core_req.valid && core_req.op != OP_NONE && core_req.op != OP_READ &&
                 core_req.addr == DM_STATUS && hw_evt == '0;
  assign st_sum = {1'b0, status_word} + {1'b0, core_req.w};

  chk_rsp_next: assert property (core_req.valid && core_req.op != OP_NONE |=> core_rsp.valid)
    else $error("core response missing one cycle after a request");
  chk_rsp_cause: assert property (core_rsp.valid |-> $past(core_req.valid) && $past(core_req.op) != OP_NONE)
    else $error("core response without a request");
  chk_reset_vec: assert property (
    $fell(srst) |-> fetch_addr == 9'h000 && status_word == 8'h18)
    else $error("wrong fetch address or status after reset");
  chk_int_vec: assert property (pc_ctl.int_accept |-> ##[1:2] fetch_addr == 9'h004)
    else $error("accepted interrupt did not branch to four");
  chk_hef_window: assert property ($stable(fetch_addr) |-> hef_low_byte == (fetch_addr >= HEF_LO))
    else $error("high-endurance flag disagrees with fetch address");
  chk_wdt_timeout: assert property (hw_evt.wdt_timeout |=> !status_word[ST_WDT])
    else $error("watchdog flag not cleared by time-out");
  chk_sleep_entry: assert property (
    hw_evt.sleep_exec && !hw_evt.wdt_timeout |=> status_word[ST_WDT] && !status_word[ST_SLEEP])
    else $error("sleep entry did not set the flags");
  chk_sw_hw_flags: assert property (st_wr |=> $stable(status_word[4:3]))
    else $error("software write changed a hardware-only flag");
  chk_move_status: assert property (
    st_wr && core_req.op == OP_MOVE_W |=> status_word[7:5] == $past(core_req.w[7:5]) &&
    status_word[2:0] == $past(core_req.w[2:0]))
    else $error("move to status not stored");
  chk_clear_status: assert property (
    st_wr && core_req.op == OP_CLEAR |=> status_word[7:5] == 3'b000 && status_word[ST_ZERO] &&
    status_word[4:3] == $past(status_word[4:3]) && status_word[1:0] == $past(status_word[1:0]))
    else $error("clear of status gave the wrong pattern");
  chk_add_status: assert property (
    st_wr && core_req.op == OP_ADD |=> status_word[ST_CARRY] == $past(st_sum[8]) &&
    status_word[ST_ZERO] == ($past(st_sum[7:0]) == 8'h00))
    else $error("add into status kept written flags");
  chk_axi_rlat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not returned one cycle after address");

endmodule : cmm_core_map_checker

`default_nettype wire

// ===== bench/test_core_memory_map_and_status.sv
`timescale 1ns/1ps
`default_nettype none

module test_core_memory_map_and_status import cmm_pkg::*;;
  logic clk = 1'b0;
  logic srst = 1'b1;
  cmm_core_req_t core_req = '0;
  cmm_pc_ctl_t pc_ctl = '0;
  cmm_hw_evt_t hw_evt = '0;
  cmm_core_rsp_t core_rsp;
  logic [8:0] fetch_addr;
  logic hef_low_byte;
  logic [7:0] status_word;
  logic [7:0] s_axi_awaddr = '0;
  logic [7:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [31:0] s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int num_errors = 0;
  int n_checks = 0;

  // Free-running 250 MHz clock.
  always #2 clk = ~clk;

  cmm_core_map dut (
    .clk(clk), .srst(srst), .core_req(core_req), .pc_ctl(pc_ctl), .hw_evt(hw_evt), .core_rsp(core_rsp),
    .fetch_addr(fetch_addr), .hef_low_byte(hef_low_byte), .status_word(status_word),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
  );

  // -------------------------------------------------------------------------
  // Access tasks
  // -------------------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // One core operation; the answer is registered at the edge that takes it.
  task automatic core_op(input cmm_op_t o, input logic [6:0] a, input logic [7:0] w);
    @(posedge clk);
    core_req <= '{valid: 1'b1, op: o, addr: a, w: w, bit_sel: 3'h0};
    @(posedge clk);
    core_req.valid <= 1'b0;
    #1;
    check(32'(core_rsp.valid), 32'h1);
  endtask : core_op

  // Extra edges let the fetch address and window flag settle whatever their register depth.
  task automatic pc_op(input cmm_pc_ctl_t c, input logic [8:0] exp);
    @(posedge clk);
    pc_ctl <= c;
    @(posedge clk);
    pc_ctl <= '0;
    repeat (2) @(posedge clk);
    #1;
    check(32'(fetch_addr), 32'(exp));
  endtask : pc_op

  task automatic hw_pulse(input cmm_hw_evt_t e, input logic [7:0] exp);
    @(posedge clk);
    hw_evt <= e;
    @(posedge clk);
    hw_evt <= '0;
    #1;
    check(32'(status_word), 32'(exp));
  endtask : hw_pulse

  // Address and data are offered together and each is dropped at the edge that takes it.
  task automatic axi_wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp_resp);
    logic done;
    done = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        check(32'(s_axi_bresp), 32'(exp_resp));
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : axi_wr_chk

  task automatic axi_rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] exp_resp);
    logic done;
    done = 1'b0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        check(s_axi_rdata, exp);
        check(32'(s_axi_rresp), 32'(exp_resp));
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : axi_rd_chk

  task automatic report_and_stop();
    $display("Checks %0d, errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  // -------------------------------------------------------------------------
  // Test sequence
  // -------------------------------------------------------------------------
  // The whole run needs well under a thousand cycles, so this limit only cuts a hang.
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    report_and_stop();
  end

  // Program counter first, then data memory, status handling and the register bus.
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    check(32'(status_word), 32'h18);
    check(32'(fetch_addr), 32'h0);
    pc_op(cmm_pc_ctl_t'{1'b0, 1'b1, 13'h1abc, 1'b0}, 9'h0bc);
    pc_op(cmm_pc_ctl_t'{1'b0, 1'b1, 13'h017f, 1'b0}, 9'h17f);
    check(32'(hef_low_byte), 32'h0);
    pc_op(cmm_pc_ctl_t'{1'b1, 1'b0, 13'h0000, 1'b0}, 9'h180);
    check(32'(hef_low_byte), 32'h1);
    pc_op(cmm_pc_ctl_t'{1'b0, 1'b1, 13'h01ff, 1'b0}, 9'h1ff);
    pc_op(cmm_pc_ctl_t'{1'b1, 1'b0, 13'h0000, 1'b0}, 9'h000);
    axi_rd_chk(AXI_PC, 32'h200, RESP_OKAY);
    pc_op(cmm_pc_ctl_t'{1'b1, 1'b1, 13'h0123, 1'b1}, 9'h004);
    core_op(OP_MOVE_W, DM_PC_LATCH_HIGH, 8'h01);
    core_op(OP_MOVE_W, DM_PC_LOW, 8'h85);
    axi_wr_chk(AXI_CTRL, 32'h1, RESP_OKAY);
    axi_rd_chk(AXI_CTRL, 32'h1, RESP_OKAY);
    axi_rd_chk(AXI_PC, 32'h185, RESP_OKAY);
    pc_op(cmm_pc_ctl_t'{1'b1, 1'b0, 13'h0000, 1'b0}, 9'h185);
    axi_wr_chk(AXI_CTRL, 32'h0, RESP_OKAY);
    pc_op(cmm_pc_ctl_t'{1'b1, 1'b0, 13'h0000, 1'b0}, 9'h186);
    core_op(OP_MOVE_W, 7'h40, 8'h0f);
    core_op(OP_ADD, 7'h40, 8'h01);
    check(32'(core_rsp.result), 32'h10);
    check(32'(status_word[2:0]), 32'h2);
    core_op(OP_ADD, 7'h40, 8'hf0);
    check(32'(status_word[2:0]), 32'h5);
    core_op(OP_MOVE_W, 7'h41, 8'h05);
    core_op(OP_SUB, 7'h41, 8'h03);
    check(32'(status_word[2:0]), 32'h3);
    core_op(OP_SUB, 7'h41, 8'h03);
    check(32'(core_rsp.result), 32'hff);
    check(32'(status_word[2:0]), 32'h0);
    core_op(OP_AND, 7'h40, 8'hff);
    check(32'(status_word[2:0]), 32'h4);
    core_op(OP_BIT_CLEAR, 7'h41, 8'h00);
    core_op(OP_NIBBLE_SWAP, 7'h41, 8'h00);
    check(32'(core_rsp.result), 32'hef);
    core_op(OP_MOVE_W, DM_POINTER, 8'h7f);
    core_op(OP_MOVE_W, DM_INDIRECT, 8'ha5);
    core_op(OP_READ, 7'h7f, 8'h00);
    check(32'(core_rsp.old_data), 32'ha5);
    core_op(OP_MOVE_W, 7'h3f, 8'h77);
    core_op(OP_READ, 7'h3f, 8'h00);
    check(32'(core_rsp.old_data), 32'h0);
    core_op(OP_MOVE_W, DM_STATUS, 8'h07);
    check(32'(status_word), 32'h1f);
    hw_pulse(cmm_hw_evt_t'(3'b100), 8'h0f);
    core_op(OP_MOVE_W, DM_STATUS, 8'h1a);
    check(32'(status_word), 32'h0a);
    core_op(OP_ADD, DM_STATUS, 8'hf6);
    check(32'(status_word), 32'h0f);
    core_op(OP_MOVE_W, DM_STATUS, 8'h00);
    core_op(OP_CLEAR, DM_STATUS, 8'h00);
    check(32'(status_word), 32'h0c);
    core_op(OP_BIT_SET, DM_STATUS, 8'h00);
    check(32'(status_word), 32'h0d);
    hw_pulse(cmm_hw_evt_t'(3'b010), 8'h1d);
    hw_pulse(cmm_hw_evt_t'(3'b001), 8'h15);
    axi_rd_chk(AXI_STATUS, 32'h15, RESP_OKAY);
    axi_wr_chk(AXI_STATUS, 32'h0, RESP_OKAY);
    check(32'(status_word), 32'h15);
    axi_wr_chk(AXI_PEEK_ADDR, 32'h41, RESP_OKAY);
    axi_rd_chk(AXI_PEEK_DATA, 32'hef, RESP_OKAY);
    axi_rd_chk(AXI_POINTER, 32'h7f, RESP_OKAY);
    axi_wr_chk(8'h30, 32'h1, RESP_SLVERR);
    axi_rd_chk(8'h30, 32'h0, RESP_SLVERR);
    report_and_stop();
  end

endmodule : test_core_memory_map_and_status

bind cmm_core_map cmm_core_map_checker u_chk (
  .clk(clk), .srst(srst), .core_req(core_req), .pc_ctl(pc_ctl), .hw_evt(hw_evt), .core_rsp(core_rsp),
  .fetch_addr(fetch_addr), .hef_low_byte(hef_low_byte), .status_word(status_word),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid)
);

`default_nettype wire
